// *** logic/dtd_defs.svh ***
// Bit positions, reset values and timeout counts of the discard timer block
`ifndef DTD_DEFS_SVH
`define DTD_DEFS_SVH

`define DTD_BIT_FAST_B2B      23
`define DTD_BIT_PRI_SEL       24
`define DTD_BIT_SEC_SEL       25
`define DTD_BIT_TMO_STATUS    26
`define DTD_BIT_TMO_SERR_EN   27
`define DTD_RESV_HI           31
`define DTD_RESV_LO           28
`define DTD_BYTE_LANE_FB2B    2
`define DTD_BYTE_LANE_UPPER   3

`define DTD_RST_FAST_B2B      1'b0
`define DTD_RST_PRI_SEL       1'b0
`define DTD_RST_SEC_SEL       1'b0
`define DTD_RST_TMO_STATUS    1'b0
`define DTD_RST_TMO_SERR_EN   1'b0

`define DTD_CNT_W             16
`define DTD_LONG_CYCLES       32768
`define DTD_SHORT_CYCLES      1024

`endif

// *** logic/dtd_pkg.sv ***
// Types shared by the discard timer block
`default_nettype none
package dtd_pkg;
    typedef enum logic [1:0] {
        DTD_IDLE,
        DTD_COUNT,
        DTD_HELD,
        DTD_DROPPED
    } dtd_state_t;
endpackage
`default_nettype wire

// *** logic/dtd_timer_if.sv ***
// Signals between the bridge control block and one discard timer
`default_nettype none
interface dtd_timer_if;
    logic head_valid;
    logic retried;
    logic sel_short;
    logic discard;
    logic running;
    modport ctrl  (output head_valid, output retried, output sel_short, input discard, input running);
    modport timer (input head_valid, input retried, input sel_short, output discard, output running);
endinterface
`default_nettype wire

// *** logic/dtd_discard_timer.sv ***
// One delayed transaction discard timer
`default_nettype none
`include "dtd_defs.svh"
module dtd_discard_timer
    import dtd_pkg::*;
#(
    parameter int unsigned LONG_CYCLES  = `DTD_LONG_CYCLES,
    parameter int unsigned SHORT_CYCLES = `DTD_SHORT_CYCLES
) (
    // Clock and reset
    input  wire logic  clock_i,
    input  wire logic  rst_i,
    // Control side
    dtd_timer_if.timer tif
);
    localparam logic [`DTD_CNT_W-1:0] LONG_LAST  = `DTD_CNT_W'(LONG_CYCLES - 1);
    localparam logic [`DTD_CNT_W-1:0] SHORT_LAST = `DTD_CNT_W'(SHORT_CYCLES - 1);

    dtd_state_t             state;
    dtd_state_t             next_state;
    logic [`DTD_CNT_W-1:0]  count;
    logic                   discard;

    wire logic [`DTD_CNT_W-1:0] last_count = tif.sel_short ? SHORT_LAST : LONG_LAST;
    wire logic                  expire     = (state == DTD_COUNT) && !tif.retried && (count == last_count);

    assign tif.discard = discard;
    assign tif.running = (state == DTD_COUNT);

    ////////////////////////////////////////////////////////////////////////
    // Sequence: wait for head, count, stop on retry, drop on expiry
    always_comb begin
        next_state = state;
        case (state)
            DTD_IDLE: begin
                if (tif.head_valid) begin
                    next_state = DTD_COUNT;
                end
            end
            DTD_COUNT: begin
                if (!tif.head_valid) begin
                    next_state = DTD_IDLE;
                end else if (tif.retried) begin
                    next_state = DTD_HELD;
                end else if (expire) begin
                    next_state = DTD_DROPPED;
                end
            end
            DTD_HELD, DTD_DROPPED: begin
                if (!tif.head_valid) begin
                    next_state = DTD_IDLE;
                end
            end
            default: next_state = DTD_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state   <= DTD_IDLE;
            count   <= '0;
            discard <= 1'b0;
        end else begin
            state   <= next_state;
            count   <= (state == DTD_COUNT) ? count + `DTD_CNT_W'(1) : '0;
            discard <= expire;
        end
    end
endmodule // dtd_discard_timer
`default_nettype wire

// *** logic/dtd_bridge_ctrl.sv ***
// Upper bridge control fields with primary and secondary discard timers
`default_nettype none
`include "dtd_defs.svh"
// Contract
// - Fast back-to-back on secondary never issued while its enable is 0; resets 0.
// - Fast back-to-back on secondary permitted while its enable is 1.
// - Primary timer bounds wait for a primary initiator to retry.
// - Each timer starts when the completion reaches its queue head.
// - Without any retry before expiry, the transaction is dropped from all queues; the code pulses only that timer's own discard output.
// - Primary select 0 (reset) gives 2^15 clocks; 1 gives 2^10.
// - Secondary timer, select bit 25, bounds secondary retry wait the same way.
// - Secondary select 0 (reset) gives 2^15 clocks; 1 gives 2^10.
// - Bit 26 sets on any timeout drop; write 1 clears; resets 0.
// - With bit 27 at 0, a timeout drop never drives system error.
// - With bit 27 and command error enable set, a drop asserts system error.
// - Bits 31:28 are reserved and read zero.
module dtd_bridge_ctrl
    import dtd_pkg::*;
#(
    parameter int unsigned LONG_CYCLES  = `DTD_LONG_CYCLES,
    parameter int unsigned SHORT_CYCLES = `DTD_SHORT_CYCLES
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // Configuration access to the bridge control dword
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic      [31:0] cfg_rdata_o,
    // Command register error enable
    input  wire logic        cmd_serr_en_i,
    // Primary delayed transaction queue
    input  wire logic        pri_head_valid_i,
    input  wire logic        pri_retried_i,
    output logic             pri_discard_o,
    // Secondary delayed transaction queue
    input  wire logic        sec_head_valid_i,
    input  wire logic        sec_retried_i,
    output logic             sec_discard_o,
    // Secondary master control
    output logic             fast_b2b_en_o,
    // Primary system error pin, open drain
    output logic             serr_out_o,
    output logic             serr_oe_o
);
    dtd_timer_if pri_if ();
    dtd_timer_if sec_if ();

    logic fast_b2b;
    logic pri_sel_short;
    logic sec_sel_short;
    logic tmo_status;
    logic tmo_serr_en;

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    // A write touches a field only when its byte lane is enabled
    function automatic logic lane_written(input logic wr, input logic [3:0] be, input int unsigned lane);
        return wr && be[lane];
    endfunction

    wire logic wr_lane2   = lane_written(cfg_wr_i, cfg_be_i, `DTD_BYTE_LANE_FB2B);
    wire logic wr_lane3   = lane_written(cfg_wr_i, cfg_be_i, `DTD_BYTE_LANE_UPPER);
    wire logic status_clr = wr_lane3 && cfg_wdata_i[`DTD_BIT_TMO_STATUS];

    ////////////////////////////////////////////////////////////////////////
    // Drop events from either timer
    wire logic pri_drop   = pri_if.discard;
    wire logic sec_drop   = sec_if.discard;
    wire logic any_drop   = pri_drop || sec_drop;
    wire logic raise_serr = any_drop && tmo_serr_en && cmd_serr_en_i;

    wire logic [31:0] read_word = {
        4'h0,
        tmo_serr_en,
        tmo_status,
        sec_sel_short,
        pri_sel_short,
        fast_b2b,
        23'h00_0000
    };

    ////////////////////////////////////////////////////////////////////////
    // Timer hookup
    assign pri_if.head_valid = pri_head_valid_i;
    assign pri_if.retried    = pri_retried_i;
    assign pri_if.sel_short  = pri_sel_short;
    assign sec_if.head_valid = sec_head_valid_i;
    assign sec_if.retried    = sec_retried_i;
    assign sec_if.sel_short  = sec_sel_short;

    dtd_discard_timer #(
        .LONG_CYCLES  (LONG_CYCLES),
        .SHORT_CYCLES (SHORT_CYCLES)
    ) u_pri_timer (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .tif     (pri_if.timer)
    );

    dtd_discard_timer #(
        .LONG_CYCLES  (LONG_CYCLES),
        .SHORT_CYCLES (SHORT_CYCLES)
    ) u_sec_timer (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .tif     (sec_if.timer)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next values of the control fields
    wire logic next_fast_b2b      = wr_lane2 ? cfg_wdata_i[`DTD_BIT_FAST_B2B] : fast_b2b;
    wire logic next_pri_sel_short = wr_lane3 ? cfg_wdata_i[`DTD_BIT_PRI_SEL] : pri_sel_short;
    wire logic next_sec_sel_short = wr_lane3 ? cfg_wdata_i[`DTD_BIT_SEC_SEL] : sec_sel_short;
    wire logic next_tmo_serr_en   = wr_lane3 ? cfg_wdata_i[`DTD_BIT_TMO_SERR_EN] : tmo_serr_en;
    // Sticky status: a drop in the clearing cycle wins
    wire logic next_tmo_status    = any_drop || (tmo_status && !status_clr);

    ////////////////////////////////////////////////////////////////////////
    // Control field registers
    // Selects are read live by the timers, so a new length applies at once
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            fast_b2b <= `DTD_RST_FAST_B2B;
        end else begin
            fast_b2b <= next_fast_b2b;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pri_sel_short <= `DTD_RST_PRI_SEL;
        end else begin
            pri_sel_short <= next_pri_sel_short;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sec_sel_short <= `DTD_RST_SEC_SEL;
        end else begin
            sec_sel_short <= next_sec_sel_short;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tmo_serr_en <= `DTD_RST_TMO_SERR_EN;
        end else begin
            tmo_serr_en <= next_tmo_serr_en;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tmo_status <= `DTD_RST_TMO_STATUS;
        end else begin
            tmo_status <= next_tmo_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next values of the outputs
    wire logic [31:0] next_cfg_rdata = cfg_rd_i ? read_word : 32'h0000_0000;
    wire logic        next_serr_oe   = raise_serr;

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_rdata_o <= 32'h0000_0000;
        end else begin
            cfg_rdata_o <= next_cfg_rdata;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pri_discard_o <= 1'b0;
        end else begin
            pri_discard_o <= pri_drop;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sec_discard_o <= 1'b0;
        end else begin
            sec_discard_o <= sec_drop;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            fast_b2b_en_o <= 1'b0;
        end else begin
            fast_b2b_en_o <= fast_b2b;
        end
    end

    // Open-drain pin: the value stays low, the enable pulls the line
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            serr_out_o <= 1'b0;
        end else begin
            serr_out_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            serr_oe_o <= 1'b0;
        end else begin
            serr_oe_o <= next_serr_oe;
        end
    end
endmodule // dtd_bridge_ctrl
`default_nettype wire

// *** testbench/dtd_bridge_ctrl_assertions.sv ***
// Concurrent checks on the bridge control ports
`default_nettype none
module dtd_bridge_ctrl_checker (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        cfg_wr_i,
    input wire logic        cfg_rd_i,
    input wire logic [3:0]  cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic        cmd_serr_en_i,
    input wire logic        pri_head_valid_i,
    input wire logic        sec_head_valid_i,
    input wire logic        pri_discard_o,
    input wire logic        sec_discard_o,
    input wire logic        fast_b2b_en_o,
    input wire logic        serr_out_o,
    input wire logic        serr_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_resv_read_zero: assert property (cfg_rdata_o[31:28] == 4'h0) else $error("reserved bits read nonzero");
    a_rdata_idle_zero: assert property (!$past(cfg_rd_i) |-> cfg_rdata_o == 32'h0000_0000)
        else $error("read data without read");
    a_fb2b_follows: assert property (cfg_wr_i && cfg_be_i[2] |-> ##2 fast_b2b_en_o == $past(cfg_wdata_i[23], 2))
        else $error("fast b2b enable not written");
    a_fb2b_holds: assert property (!$past(cfg_wr_i, 2) |-> $stable(fast_b2b_en_o)) else $error("fast b2b moved");
    a_pri_drop_pulse: assert property (pri_discard_o |=> !pri_discard_o) else $error("primary drop not a pulse");
    a_sec_drop_pulse: assert property (sec_discard_o |=> !sec_discard_o) else $error("secondary drop not a pulse");
    a_pri_drop_head: assert property (pri_discard_o |-> $past(pri_head_valid_i, 3)) else $error("primary drop no head");
    a_sec_drop_head: assert property (sec_discard_o |-> $past(sec_head_valid_i, 3)) else $error("secondary drop no head");
    a_serr_on_drop: assert property (serr_oe_o |-> (pri_discard_o || sec_discard_o) && $past(cmd_serr_en_i))
        else $error("system error without drop");
    a_serr_low_value: assert property (serr_out_o == 1'b0) else $error("system error value high");
endmodule // dtd_bridge_ctrl_checker
bind dtd_bridge_ctrl dtd_bridge_ctrl_checker i_chk (
    .clock_i          (clock_i),
    .rst_i            (rst_i),
    .cfg_wr_i         (cfg_wr_i),
    .cfg_rd_i         (cfg_rd_i),
    .cfg_be_i         (cfg_be_i),
    .cfg_wdata_i      (cfg_wdata_i),
    .cfg_rdata_o      (cfg_rdata_o),
    .cmd_serr_en_i    (cmd_serr_en_i),
    .pri_head_valid_i (pri_head_valid_i),
    .sec_head_valid_i (sec_head_valid_i),
    .pri_discard_o    (pri_discard_o),
    .sec_discard_o    (sec_discard_o),
    .fast_b2b_en_o    (fast_b2b_en_o),
    .serr_out_o       (serr_out_o),
    .serr_oe_o        (serr_oe_o)
);
`default_nettype wire

// *** testbench/dtd_initiator_model.sv ***
// Initiator that repeats a retried request after a set wait
`default_nettype none
module dtd_initiator_model (
    // Clock and queue head
    input  wire logic        clock_i,
    input  wire logic        head_i,
    // Retry wait in cycles, zero means never
    input  wire logic [15:0] wait_i,
    // Retry seen by the bridge
    output logic             retried_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cnt;
    always_ff @(posedge clock_i) begin
        cnt       <= head_i ? cnt + 16'h0001 : 16'h0000;
        retried_o <= head_i && wait_i != 16'h0000 && cnt == wait_i;
    end
endmodule // dtd_initiator_model
`default_nettype wire

// *** testbench/dtd_bridge_ctrl_tb.sv ***
// Self-checking bench for the bridge control discard timers
`default_nettype none
module dtd_bridge_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LONG = 40;
    localparam int SHORT = 8;
    logic        clock_i, rst_i, cfg_wr_i, cfg_rd_i, cmd_serr_en_i, fast_b2b_en_o, serr_out_o, serr_oe_o;
    logic        pri_head_valid_i, pri_retried_i, pri_discard_o, sec_head_valid_i, sec_retried_i, sec_discard_o;
    logic [3:0]  cfg_be_i;
    logic [31:0] cfg_wdata_i, cfg_rdata_o, d;
    logic [15:0] wait_c;
    int          err_count, n_compared, seed;
    dtd_bridge_ctrl #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT)) i_dut (
        .clock_i          (clock_i),
        .rst_i            (rst_i),
        .cfg_wr_i         (cfg_wr_i),
        .cfg_rd_i         (cfg_rd_i),
        .cfg_be_i         (cfg_be_i),
        .cfg_wdata_i      (cfg_wdata_i),
        .cfg_rdata_o      (cfg_rdata_o),
        .cmd_serr_en_i    (cmd_serr_en_i),
        .pri_head_valid_i (pri_head_valid_i),
        .pri_retried_i    (pri_retried_i),
        .pri_discard_o    (pri_discard_o),
        .sec_head_valid_i (sec_head_valid_i),
        .sec_retried_i    (sec_retried_i),
        .sec_discard_o    (sec_discard_o),
        .fast_b2b_en_o    (fast_b2b_en_o),
        .serr_out_o       (serr_out_o),
        .serr_oe_o        (serr_oe_o)
    );
    dtd_initiator_model i_pri (.clock_i(clock_i), .head_i(pri_head_valid_i), .wait_i(wait_c), .retried_o(pri_retried_i));
    dtd_initiator_model i_sec (.clock_i(clock_i), .head_i(sec_head_valid_i), .wait_i(wait_c), .retried_o(sec_retried_i));
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    task automatic conclude();
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] be, input logic [31:0] v);
        @(posedge clock_i);
        cfg_wr_i    <= 1'b1;
        cfg_be_i    <= be;
        cfg_wdata_i <= v;
        @(posedge clock_i);
        cfg_wr_i    <= 1'b0;
    endtask
    task automatic rd(output logic [31:0] v);
        @(posedge clock_i);
        cfg_rd_i <= 1'b1;
        @(posedge clock_i);
        cfg_rd_i <= 1'b0;
        @(negedge clock_i);
        v = cfg_rdata_o;
    endtask
    // One delayed completion at a queue head, with or without a timely retry
    task automatic run(input bit sec, input bit sel, input bit serr, input bit cmd, input bit retry);
        int n, e, t, tp = 0, ts = 0, tq = 0;
        logic [31:0] exp;
        n   = sel ? SHORT : LONG;
        // Head sampled one edge late, n counting cycles, one to drop, one to register
        e   = retry ? 0 : n + 3;
        // The idle bus gets the other select, so a swapped select shows up
        exp = {4'h0, serr, 1'b0, sec ? sel : !sel, sec ? !sel : sel, 24'h0};
        @(posedge clock_i);
        cmd_serr_en_i <= cmd;
        wait_c <= retry ? 16'(($unsigned($random(seed)) % (n - 1)) + 1) : 16'h0000;
        wr(4'b1000, exp);
        @(posedge clock_i);
        if (sec) sec_head_valid_i <= 1'b1;
        else pri_head_valid_i <= 1'b1;
        for (t = 1; t <= n + 8; t++) begin
            @(negedge clock_i);
            if (pri_discard_o === 1'b1) tp = t;
            if (sec_discard_o === 1'b1) ts = t;
            if (serr_oe_o === 1'b1) tq = t;
        end
        chk(tp, sec ? 0 : e);
        chk(ts, sec ? e : 0);
        chk(tq, (serr && cmd_serr_en_i) ? e : 0);
        @(posedge clock_i);
        pri_head_valid_i <= 1'b0;
        sec_head_valid_i <= 1'b0;
        exp[26] = !retry;
        rd(d);
        chk(d, exp);
        wr(4'b1000, exp);
        exp[26] = 1'b0;
        rd(d);
        chk(d, exp);
    endtask
    initial begin
        seed = 32'hce3f_dbb9;
        {rst_i, cfg_wr_i, cfg_rd_i, cmd_serr_en_i, pri_head_valid_i, sec_head_valid_i} = 6'b10_0000;
        cfg_be_i    = 4'h0;
        cfg_wdata_i = 32'h0000_0000;
        wait_c      = 16'h0000;
        err_count   = 0;
        n_compared  = 0;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(d);
        chk(d, 32'h0000_0000);
        wr(4'b1111, 32'hffff_ffff);
        rd(d);
        chk(d, 32'h0b80_0000);
        chk({31'h0, fast_b2b_en_o}, 32'h0000_0001);
        wr(4'b0100, 32'h0000_0000);
        rd(d);
        chk(d, 32'h0b00_0000);
        chk({31'h0, fast_b2b_en_o}, 32'h0000_0000);
        for (int i = 0; i < 16; i++) run(i[0], i[1], i[2], i[3], 1'b0);
        for (int i = 0; i < 4; i++) run(i[0], i[1], 1'b1, 1'($random(seed)), 1'b1);
        conclude();
    end
    initial begin
        #500_000;
        err_count++;
        conclude();
    end
endmodule // dtd_bridge_ctrl_tb
`default_nettype wire
